// ===== hw/rft_pkg.sv
// Shared constants and types for the RTU frame timing block.
package rft_pkg;

  // Clock.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ_DEF    = 1000000000 / CLK_PERIOD_NS;
  localparam int NS_PER_MS     = 1000000;

  // Baud rate selection.
  typedef enum logic [2:0] {
    BAUD_2400,
    BAUD_4800,
    BAUD_9600,
    BAUD_19200,
    BAUD_38400
  } rft_baud_e;

  localparam int BAUD_2400_BPS  = 2400;
  localparam int BAUD_4800_BPS  = 4800;
  localparam int BAUD_9600_BPS  = 9600;
  localparam int BAUD_19200_BPS = 19200;
  localparam int BAUD_38400_BPS = 38400;

  // Three-character time in ms for each rate.
  localparam logic [12:0] THREE_CHAR_MS_2400 = 13'h000f;
  localparam logic [12:0] THREE_CHAR_MS_4800 = 13'h000a;
  localparam logic [12:0] THREE_CHAR_MS_FAST = 13'h0005;

  // Idle gap that delimits frames, in bit times.
  localparam logic [5:0] GAP_BITS = 6'h21;

  // Response delay setting: units of 10 ms, 0 to 100, default 1.
  localparam logic [6:0]  RESP_DELAY_MAX     = 7'h64;
  localparam logic [6:0]  RESP_DELAY_DEF     = 7'h01;
  localparam logic [12:0] RESP_DELAY_UNIT_MS = 13'h000a;

  // Processing times in ms.
  localparam logic [12:0] PROC_STEP_MS       = 13'h0005;
  localparam logic [12:0] PROC_READ_MARGIN_MS = 13'h0005;
  localparam logic [12:0] PROC_WRITE_PER_MS  = 13'h0014;
  localparam logic [12:0] PROC_WRITE_ADD_MS  = 13'h000a;
  localparam logic [12:0] PROC_DIAG_MS       = 13'h000a;
  localparam logic [12:0] PROC_INIT_FULL_MS  = 13'h1388;
  localparam logic [12:0] PROC_INIT_MOTOR_MS = 13'h01f4;
  localparam int          READ_GROUP_SHIFT   = 3;

  // Kind of query, as classified by the frame parser.
  typedef enum logic [2:0] {
    QRY_READ,
    QRY_WRITE,
    QRY_DIAG,
    QRY_INIT_FULL,
    QRY_INIT_MOTOR
  } rft_qry_e;

  // Response sequencer states.
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_RESP_WAIT,
    ST_TRANSMIT,
    ST_TURNAROUND,
    ST_BCAST_EXEC
  } rft_state_e;

endpackage

// ===== hw/rft_pair_buf.sv
// Two-entry buffer with valid and ready on both sides.
module rft_pair_buf #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  if (WIDTH < 1) begin
    $error("rft_pair_buf: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_r [2];
  logic             wrPtr_r;
  logic             rdPtr_r;
  logic [1:0]       count_r;

  wire doWrite = inValid && inReady;
  wire doRead  = outValid && outReady;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      wrPtr_r <= wrPtr_r ^ doWrite;
      rdPtr_r <= rdPtr_r ^ doRead;
      count_r <= count_r + {1'b0, doWrite} - {1'b0, doRead};
    end
  end

endmodule

// ===== hw/rft_frame_timing.sv
// RTU slave frame delimiting and response timing.
// Function
// - Response waits longest of delay, 3-char, processing.
// - Delay setting 0 to 1 s, default 10 ms.
// - Three-char time 15/10/5 ms by baud.
// - Read processing int((n-1)/8)*5 plus up to 5.
// - Write processing n*20+5 to n*20+10 ms.
// - Full init 5 s, motor reinit 500 ms.
// - Diagnostic query processing takes 10 ms.
// - Three-char turnaround after response before receiving.
// - Broadcast executes, then back to receive enabled.
// - Never respond to a broadcast query.
// - 33-bit idle in standby clears frame state.
// - Three-char gap inside a frame discards it.
// - Track all frames; wait 33 bits before transmitting.
module rft_frame_timing #(
  parameter int CLK_HZ = rft_pkg::CLK_HZ_DEF
) (
  input  wire logic       clk,
  input  wire logic       srst,
  // Line settings.
  input  wire logic [2:0] baudSel,
  input  wire logic       respDelayLoad,
  input  wire logic [6:0] respDelayValue,
  output logic      [6:0] respDelay,
  // Characters from the receiver.
  input  wire logic       rxValid,
  input  wire logic [7:0] rxData,
  output logic            rxReady,
  output logic            rxOverrun,
  // Byte stream to the frame parser; bit 8 marks a frame's first byte.
  output logic            frmValid,
  input  wire logic       frmReady,
  output logic      [7:0] frmData,
  output logic            frmFirst,
  output logic            frmGap,
  output logic            frmDiscard,
  // Parsed query from the frame parser.
  input  wire logic       qryValid,
  input  wire logic [2:0] qryKind,
  input  wire logic [6:0] qryCount,
  input  wire logic       qryForUs,
  input  wire logic       qryBroadcast,
  // Transmitter side.
  output logic            txStart,
  input  wire logic       txDone,
  output logic            txEnable,
  output logic            rxEnable,
  output logic            busy
);

  // Cycle counts derived from the clock rate.
  localparam int MS_CYCLES = CLK_HZ / 1000;

  if (CLK_HZ / rft_pkg::BAUD_38400_BPS < 2) begin
    $error("rft_frame_timing: CLK_HZ too low for the fastest baud rate");
  end
  if (MS_CYCLES < 2) begin
    $error("rft_frame_timing: CLK_HZ too low for the ms tick");
  end

  function automatic logic [31:0] bitCycles(input logic [2:0] sel);
    case (sel)
      rft_pkg::BAUD_2400:  bitCycles = 32'(CLK_HZ / rft_pkg::BAUD_2400_BPS);
      rft_pkg::BAUD_4800:  bitCycles = 32'(CLK_HZ / rft_pkg::BAUD_4800_BPS);
      rft_pkg::BAUD_9600:  bitCycles = 32'(CLK_HZ / rft_pkg::BAUD_9600_BPS);
      rft_pkg::BAUD_19200: bitCycles = 32'(CLK_HZ / rft_pkg::BAUD_19200_BPS);
      default:             bitCycles = 32'(CLK_HZ / rft_pkg::BAUD_38400_BPS);
    endcase
  endfunction

  // Three-character time per baud rate; unknown codes take the fast value.
  function automatic logic [12:0] threeCharMs(input logic [2:0] sel);
    case (sel)
      rft_pkg::BAUD_2400: threeCharMs = rft_pkg::THREE_CHAR_MS_2400;
      rft_pkg::BAUD_4800: threeCharMs = rft_pkg::THREE_CHAR_MS_4800;
      default:            threeCharMs = rft_pkg::THREE_CHAR_MS_FAST;
    endcase
  endfunction

  // Processing time is taken at the top of each documented range so that
  // the reply never overtakes the work it reports on.
  function automatic logic [12:0] procMs(input logic [2:0] kind, input logic [6:0] n);
    logic [12:0] nw;
    logic [12:0] groups;
    nw     = {6'h00, n};
    groups = (nw == 13'h0000) ? 13'h0000 : ((nw - 13'h0001) >> rft_pkg::READ_GROUP_SHIFT);
    case (kind)
      rft_pkg::QRY_READ:
        procMs = 13'(groups * rft_pkg::PROC_STEP_MS) + rft_pkg::PROC_READ_MARGIN_MS;
      rft_pkg::QRY_WRITE:
        procMs = 13'(nw * rft_pkg::PROC_WRITE_PER_MS) + rft_pkg::PROC_WRITE_ADD_MS;
      rft_pkg::QRY_DIAG:       procMs = rft_pkg::PROC_DIAG_MS;
      rft_pkg::QRY_INIT_FULL:  procMs = rft_pkg::PROC_INIT_FULL_MS;
      rft_pkg::QRY_INIT_MOTOR: procMs = rft_pkg::PROC_INIT_MOTOR_MS;
      default:                 procMs = rft_pkg::PROC_DIAG_MS;
    endcase
  endfunction

  rft_pkg::rft_state_e state_r;
  rft_pkg::rft_state_e state_nxt;

  logic [31:0] bitDiv_r;
  logic [5:0]  gapBits_r;
  logic [31:0] msDiv_r;
  logic [12:0] msElapsed_r;
  logic [12:0] target_r;
  logic        frmActive_r;
  logic        frmDone_r;
  logic        firstPending_r;
  logic        frmGap_r;
  logic        frmDiscard_r;
  logic        txStart_r;
  logic        rxOverrun_r;
  logic [6:0]  respDelay_r;

  // Bit-time tick, realigned on every character so the gap is measured
  // from the character's end.
  wire [31:0] bitLimit = bitCycles(baudSel) - 32'h00000001;
  // A rate change while idle can leave the divider above the new limit,
  // so the compare is not an equality that could wait for a full wrap.
  wire        bitTick  = (bitDiv_r >= bitLimit);
  wire        gapHit   = bitTick && (gapBits_r == rft_pkg::GAP_BITS - 6'h01);

  // The ms tick restarts at each received character and at the end of
  // transmission so that every interval starts on its own event.
  wire        msRestart = rxValid || txDone;
  wire        msTick    = (msDiv_r == 32'(MS_CYCLES - 1));
  wire        msSat     = (msElapsed_r == 13'h1fff);

  // Response interval: the largest of the three candidates.
  wire [12:0] delayMs  = 13'(respDelay_r * rft_pkg::RESP_DELAY_UNIT_MS);
  wire [12:0] charMs   = threeCharMs(baudSel);
  wire [12:0] workMs   = procMs(qryKind, qryCount);
  wire [12:0] maxDC    = (delayMs > charMs) ? delayMs : charMs;
  wire [12:0] respMs   = (maxDC > workMs) ? maxDC : workMs;

  wire        qryOurs  = qryValid && qryForUs && !qryBroadcast;
  wire        qryBcast = qryValid && qryBroadcast;
  wire        timeUp   = (msElapsed_r >= target_r);
  wire        delayOk  = (respDelayValue <= rft_pkg::RESP_DELAY_MAX);

  // Receive path into the two-entry buffer; a word that meets a full
  // buffer is dropped and reported, since the receiver cannot stall.
  wire        bufInReady;
  wire [8:0]  bufOut;
  wire        rxTake   = rxValid && bufInReady;
  wire        startNew = !frmActive_r || firstPending_r;

  assign rxReady   = bufInReady;
  assign frmData   = bufOut[7:0];
  assign frmFirst  = bufOut[8];
  assign frmGap    = frmGap_r;
  assign frmDiscard = frmDiscard_r;
  assign txStart   = txStart_r;
  assign rxOverrun = rxOverrun_r;
  assign respDelay = respDelay_r;
  assign txEnable  = (state_r == rft_pkg::ST_TRANSMIT);
  assign rxEnable  = (state_r != rft_pkg::ST_TRANSMIT) &&
                     (state_r != rft_pkg::ST_TURNAROUND);
  assign busy      = (state_r != rft_pkg::ST_STANDBY);

  rft_pair_buf #(
    .WIDTH (9)
  ) u_buf (
    .clk      (clk),
    .srst     (srst),
    .inValid  (rxValid),
    .inReady  (bufInReady),
    .inData   ({startNew, rxData}),
    .outValid (frmValid),
    .outReady (frmReady),
    .outData  (bufOut)
  );

  always_ff @(posedge clk) begin
    if (srst || rxValid || bitTick) begin
      bitDiv_r <= 32'h00000000;
    end else begin
      bitDiv_r <= bitDiv_r + 32'h00000001;
    end
  end

  // Idle bit counter; counts frames to any station, so the gap also
  // spaces our reply from another station's traffic.
  always_ff @(posedge clk) begin
    if (srst || rxValid) begin
      gapBits_r <= 6'h00;
    end else if (bitTick && (gapBits_r != rft_pkg::GAP_BITS)) begin
      gapBits_r <= gapBits_r + 6'h01;
    end
  end

  // Frame state: active from the first byte until the idle gap.
  always_ff @(posedge clk) begin
    if (srst) begin
      frmActive_r    <= 1'b0;
      frmDone_r      <= 1'b0;
      firstPending_r <= 1'b0;
      frmGap_r       <= 1'b0;
      frmDiscard_r   <= 1'b0;
    end else begin
      frmGap_r     <= gapHit && frmActive_r;
      frmDiscard_r <= gapHit && frmActive_r && !frmDone_r && !qryValid;
      if (gapHit) begin
        frmActive_r <= 1'b0;
        frmDone_r   <= 1'b0;
      end else begin
        if (rxValid) begin
          frmActive_r <= 1'b1;
        end
        if (qryValid) begin
          frmDone_r <= 1'b1;
        end
      end
      // A first byte lost to overrun passes the first mark to the next one.
      if (gapHit) begin
        firstPending_r <= 1'b0;
      end else if (rxValid) begin
        firstPending_r <= startNew && !rxTake;
      end
      if (rxValid && !frmActive_r) begin
        frmDone_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxOverrun_r <= 1'b0;
    end else begin
      rxOverrun_r <= rxValid && !bufInReady;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      respDelay_r <= rft_pkg::RESP_DELAY_DEF;
    end else if (respDelayLoad && delayOk) begin
      respDelay_r <= respDelayValue;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || msRestart || msTick) begin
      msDiv_r <= 32'h00000000;
    end else begin
      msDiv_r <= msDiv_r + 32'h00000001;
    end
  end

  // Milliseconds since the last character or since the end of our reply.
  always_ff @(posedge clk) begin
    if (srst || msRestart) begin
      msElapsed_r <= 13'h0000;
    end else if (msTick && !msSat) begin
      msElapsed_r <= msElapsed_r + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      target_r <= 13'h0000;
    end else if ((state_r == rft_pkg::ST_STANDBY) && qryOurs) begin
      target_r <= respMs;
    end else if ((state_r == rft_pkg::ST_STANDBY) && qryBcast) begin
      target_r <= workMs;
    end else if (txDone && (state_r == rft_pkg::ST_TRANSMIT)) begin
      target_r <= charMs;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rft_pkg::ST_STANDBY: begin
        if (qryBcast) begin
          state_nxt = rft_pkg::ST_BCAST_EXEC;
        end else if (qryOurs) begin
          state_nxt = rft_pkg::ST_RESP_WAIT;
        end
      end
      rft_pkg::ST_RESP_WAIT: begin
        if (timeUp && !msRestart && (gapBits_r == rft_pkg::GAP_BITS)) begin
          state_nxt = rft_pkg::ST_TRANSMIT;
        end
      end
      rft_pkg::ST_TRANSMIT: begin
        if (txDone) begin
          state_nxt = rft_pkg::ST_TURNAROUND;
        end
      end
      rft_pkg::ST_TURNAROUND: begin
        if (timeUp && !msRestart) begin
          state_nxt = rft_pkg::ST_STANDBY;
        end
      end
      rft_pkg::ST_BCAST_EXEC: begin
        if (timeUp && !msRestart) begin
          state_nxt = rft_pkg::ST_STANDBY;
        end
      end
      default: begin
        state_nxt = rft_pkg::ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r   <= rft_pkg::ST_STANDBY;
      txStart_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      txStart_r <= (state_r == rft_pkg::ST_RESP_WAIT) &&
                   (state_nxt == rft_pkg::ST_TRANSMIT);
    end
  end

endmodule

// ===== verif/rft_frame_timing_chk.sv
// Port assertions for the RTU frame timing block.
module rft_frame_timing_chk #(
  parameter int CLK_HZ = 250000000
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [2:0] baudSel,
  input wire logic [6:0] respDelay,
  input wire logic       rxValid,
  input wire logic       rxOverrun,
  input wire logic       frmGap,
  input wire logic       qryValid,
  input wire logic       qryForUs,
  input wire logic       qryBroadcast,
  input wire logic       txStart,
  input wire logic       txDone,
  input wire logic       txEnable,
  input wire logic       rxEnable,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = CLK_HZ / 1000;
  logic [31:0] rxAge_r;
  logic [31:0] doneAge_r;
  logic        bcast_r;
  wire  [31:0] bps = baudSel == 3'h0 ? 2400 : baudSel == 3'h1 ? 4800 :
                     baudSel == 3'h2 ? 9600 : baudSel == 3'h3 ? 19200 : 38400;
  wire  [31:0] gapCyc = 33 * (CLK_HZ / bps);
  wire  [31:0] threeCyc = MS * (baudSel == 3'h0 ? 15 : baudSel == 3'h1 ? 10 : 5);
  // Two cycles of slack absorb the registered outputs.
  always_ff @(posedge clk) begin
    rxAge_r   <= (srst || rxValid) ? 32'h0 : rxAge_r + 32'h1;
    doneAge_r <= (srst || txDone) ? 32'h0 : doneAge_r + 32'h1;
    bcast_r   <= !srst && ((qryValid && qryBroadcast && !busy) || (bcast_r && busy));
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_delay; txStart |-> rxAge_r + 32'h2 >= respDelay * 10 * MS; endproperty
  a_delay: assert property (p_delay) else $error("reply before delay");
  property p_range; respDelay <= 7'h64; endproperty
  a_range: assert property (p_range) else $error("delay out of range");
  property p_three; txStart |-> rxAge_r + 32'h2 >= threeCyc; endproperty
  a_three: assert property (p_three) else $error("reply too early");
  property p_idle; txStart |-> rxAge_r >= gapCyc; endproperty
  a_idle: assert property (p_idle) else $error("reply inside idle gap");
  property p_bcast; bcast_r |-> !txStart && !txEnable; endproperty
  a_bcast: assert property (p_bcast) else $error("reply to broadcast");
  property p_turn; $rose(rxEnable) |-> doneAge_r + 32'h2 >= threeCyc; endproperty
  a_turn: assert property (p_turn) else $error("short turnaround");
  property p_dir; txEnable || !busy |-> txEnable != rxEnable; endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_take; qryValid && qryForUs && !qryBroadcast && !busy |=> busy ##1 busy; endproperty
  a_take: assert property (p_take) else $error("query not taken");
  property p_gap; frmGap |-> rxAge_r + 32'h2 >= gapCyc && rxAge_r <= gapCyc + 32'h2; endproperty
  a_gap: assert property (p_gap) else $error("gap timing");
  c_tx: cover property (txStart);
  c_gap: cover property (frmGap);
  c_ovr: cover property (rxOverrun);
endmodule

bind rft_frame_timing rft_frame_timing_chk #(.CLK_HZ(CLK_HZ)) u_rft_frame_timing_chk (
  .clk, .srst, .baudSel, .respDelay, .rxValid, .rxOverrun, .frmGap, .qryValid, .qryForUs,
  .qryBroadcast, .txStart, .txDone, .txEnable, .rxEnable, .busy
);

// ===== verif/rft_host_model.sv
// Host model that sends query characters into the receive stream.
module rft_host_model (
  input  wire logic       clk,
  output logic            rxValid,
  output logic      [7:0] rxData
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
  end
  // Gaps stay far below three character times so a frame is never split.
  task automatic send(input int n, input int gap, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      rxValid = 1'b1;
      rxData  = base + 8'(i);
      @(posedge clk);
      #1;
      if (gap > 0) begin
        rxValid = 1'b0;
        // An idle line must not look like the last byte.
        rxData = ~rxData;
        repeat (gap) @(posedge clk);
        #1;
      end
    end
    rxValid = 1'b0;
  endtask
endmodule

// ===== verif/rft_frame_timing_bench.sv
// Self-checking bench for the RTU frame timing block.
module rft_frame_timing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // A slow clock figure keeps millisecond counts short.
  localparam int CLK_HZ = 200000;
  localparam int MS     = CLK_HZ / 1000;
  logic       clk, srst, respDelayLoad, rxValid, rxReady, rxOverrun, frmValid, frmReady;
  logic       frmFirst, frmGap, frmDiscard, qryValid, qryForUs, qryBroadcast;
  logic       txStart, txDone, txEnable, rxEnable, busy;
  logic [2:0] baudSel, qryKind;
  logic [6:0] respDelayValue, respDelay, qryCount;
  logic [7:0] rxData, frmData;
  int         num_errors, checks_done, cycles, sinceRx;

  rft_frame_timing #(.CLK_HZ(CLK_HZ)) u_rft_frame_timing (
    .clk, .srst, .baudSel, .respDelayLoad, .respDelayValue, .respDelay, .rxValid, .rxData,
    .rxReady, .rxOverrun, .frmValid, .frmReady, .frmData, .frmFirst, .frmGap, .frmDiscard,
    .qryValid, .qryKind, .qryCount, .qryForUs, .qryBroadcast, .txStart, .txDone, .txEnable,
    .rxEnable, .busy
  );
  rft_host_model u_rft_host_model (.clk, .rxValid, .rxData);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // The run limit ends a hung run as a failure; the host's reply timeout is the retry loop in query.
  always @(posedge clk) begin
    sinceRx <= rxValid ? 0 : sinceRx + 1;
    cycles  <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic load(input logic [6:0] v);
    respDelayValue = v;
    respDelayLoad  = 1'b1;
    tick(1);
    respDelayLoad = 1'b0;
    tick(1);
  endtask

  task automatic reset_and_delay();
    check(32'({respDelay, rxReady, txEnable, rxEnable, busy, frmValid}), 32'h34, "reset");
    load(7'h65);
    check(32'(respDelay), 32'h1, "over range");
    load(7'h64);
    check(32'(respDelay), 32'h64, "max delay");
    load(7'h00);
    $display("delay test done");
  endtask

  // One query at a time, each run back to standby before the next.
  task automatic query(input logic [2:0] b, input logic [2:0] k, input logic [6:0] n,
                       input logic bc, input int expMs);
    int   e  = expMs * MS;
    int   t3 = MS * (b == 3'h0 ? 15 : b == 3'h1 ? 10 : 5);
    int   w;
    int   tries;
    logic tx = 1'b0;
    baudSel = b;
    u_rft_host_model.send(3, 2, 8'h10);
    qryKind      = k;
    qryCount     = n;
    qryForUs     = 1'b1;
    qryBroadcast = bc;
    qryValid     = 1'b1;
    tick(1);
    qryValid = 1'b0;
    check(32'(busy), 32'h1, "taken");
    // The host gives up on a silent device after its timeout and resends.
    for (tries = 1; tries <= 3; tries++) begin
      if (tries > 1) begin
        u_rft_host_model.send(3, 2, 8'h10);
      end
      for (w = 0; w < e + 2 * MS && (bc ? busy : !txStart); w++) begin
        tx |= txStart;
        tick(1);
      end
      if (bc ? !busy : txStart) begin
        break;
      end
    end
    tx |= txStart;
    check(32'(tries), 32'h1, "retries");
    check(32'(sinceRx + 4 >= e && sinceRx <= e + 4), 32'h1, "interval");
    if (bc) begin
      check(32'({tx, rxEnable}), 32'h1, "broadcast");
    end else begin
      tick(1);
      check(32'({txEnable, rxEnable}), 32'h2, "transmit");
      tick(8);
      txDone = 1'b1;
      tick(1);
      txDone = 1'b0;
      check(32'({txEnable, rxEnable}), 32'h0, "turning");
      for (w = 1; w < 40000 && !rxEnable; w++)
        tick(1);
      check(32'(w + 4 >= t3 && w <= t3 + 4), 32'h1, "turnaround");
    end
    check(32'(busy), 32'h0, "standby");
    $display("query test done, %0d ms", expMs);
  endtask

  task automatic stall_and_gap();
    logic g = 1'b0;
    logic d = 1'b0;
    baudSel  = 3'h4;
    frmReady = 1'b0;
    u_rft_host_model.send(3, 0, 8'h30);
    check(32'({rxOverrun, rxReady}), 32'h2, "overrun");
    check(32'({frmValid, frmFirst, frmData}), 32'h330, "first byte");
    frmReady = 1'b1;
    tick(1);
    check(32'({frmValid, frmFirst, frmData}), 32'h231, "second byte");
    tick(1);
    check(32'(frmValid), 32'h0, "drained");
    for (int i = 0; i < 400; i++) begin
      g |= frmGap;
      d |= frmDiscard;
      tick(1);
    end
    check(32'({g, d}), 32'h3, "gap discard");
    $display("stall and gap test done");
  endtask

  initial begin
    srst           = 1'b1;
    baudSel        = 3'h2;
    respDelayLoad  = 1'b0;
    respDelayValue = 7'h01;
    frmReady       = 1'b1;
    qryValid       = 1'b0;
    qryKind        = 3'h0;
    qryCount       = 7'h01;
    qryForUs       = 1'b0;
    qryBroadcast   = 1'b0;
    txDone         = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(1);
    reset_and_delay();
    query(3'h0, rft_pkg::QRY_READ, 7'h09, 1'b0, 15);
    query(3'h1, rft_pkg::QRY_READ, 7'h01, 1'b0, 10);
    query(3'h2, rft_pkg::QRY_READ, 7'h11, 1'b0, 15);
    query(3'h4, rft_pkg::QRY_WRITE, 7'h02, 1'b0, 50);
    query(3'h3, rft_pkg::QRY_DIAG, 7'h01, 1'b0, 10);
    load(7'h03);
    query(3'h2, rft_pkg::QRY_READ, 7'h01, 1'b0, 30);
    query(3'h2, rft_pkg::QRY_DIAG, 7'h01, 1'b1, 10);
    stall_and_gap();
    complete_run();
  end
endmodule
